// ===== rtl/uspm_count.sv
// timeout counter: counts while enabled, pulses done once at the limit
`timescale 1ns/100ps
module uspm_count #(
  parameter int LIMIT = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic run,
  output logic done
);
  logic [31:0] cnt_q;
  // count up while run, hold at limit so done pulses once
  always_ff @(posedge clk) begin
    if (reset || !run) begin
      cnt_q <= 32'h0000_0000;
    end else if (cnt_q != LIMIT[31:0]) begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end
  assign done = run && (cnt_q == LIMIT[31:0] - 32'h0000_0001);
endmodule // uspm_count

// ===== rtl/uspm_map.svh
// register offsets, reset values and timing counts of the suspend/mode block
`ifndef USPM_MAP_SVH
`define USPM_MAP_SVH
`define USPM_OFS_LINE 8'h1a
`define USPM_OFS_EPMS 8'h1b
`define USPM_OFS_CLK 8'h1c
`define USPM_LINE_RESET 8'hc0
`define USPM_EPMS_RESET 8'h00
`define USPM_CLK_RESET 8'h00
`define USPM_SUSPEND_MS 3
`define USPM_CLK_MHZ 100
`define USPM_SUSPEND_CYC (`USPM_SUSPEND_MS * 1000 * `USPM_CLK_MHZ)
`define USPM_WAKE_US 2000
`define USPM_WAKE_CYC (`USPM_WAKE_US * `USPM_CLK_MHZ)
`define USPM_RESET_US 10
`define USPM_RESET_CYC (`USPM_RESET_US * `USPM_CLK_MHZ)
`endif

// ===== rtl/uspm_pkg.sv
// types of the suspend/mode block
package uspm_pkg;
  typedef enum logic [1:0] {
    USPM_ACTIVE = 2'b00,
    USPM_SUSP = 2'b01,
    USPM_RESUMING = 2'b11
  } uspm_bus_t;
  typedef struct packed {
    logic dp;
    logic dm;
  } uspm_lines_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } uspm_req_t;
endpackage

// ===== rtl/uspm_top.sv
// suspend, resume, remote wake-up, bus reset and usb/ps2 line mode control
//
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
`include "uspm_map.svh"
module uspm_top #(
  parameter int SUSPEND_CYC = `USPM_SUSPEND_CYC,
  parameter int WAKE_CYC = `USPM_WAKE_CYC,
  parameter int RESET_CYC = `USPM_RESET_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire uspm_pkg::uspm_req_t req,
  output logic [7:0] rdata,
  input wire uspm_pkg::uspm_lines_t line_in,
  output uspm_pkg::uspm_lines_t line_out,
  output uspm_pkg::uspm_lines_t line_oe_n,
  input wire uspm_pkg::uspm_lines_t sie_out,
  input wire uspm_pkg::uspm_lines_t sie_oe_n,
  input wire logic bus_activity,
  input wire logic ep0_access,
  input wire logic ep1_access,
  input wire logic int_allowed,
  output logic usb_irq,
  output logic bus_clock_enable,
  output logic second_suspend_resistor,
  output logic oscillator_rate_select,
  output logic remote_wake_pulse
);
  import uspm_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    uspm_bus_t bus;
    logic suspend;
    logic resume;
    logic bus_reset_event;
    logic legacy_data_out;
    logic legacy_clock_out;
    logic endpoint_zero_request;
    logic endpoint_one_request;
    logic keyboard_port_select;
    logic serial_bus_select;
    logic usb_mode_indicator;
    logic clk_en;
    logic resistor;
    logic rate_sel;
    logic legacy_mode_indicator;
    logic wake;
    logic irq;
    logic [7:0] rdata;
  } uspm_state_t;

  uspm_state_t s_q;
  uspm_state_t s_d;

  logic idle_done;
  logic wake_done;
  logic se0_done;
  logic se0;
  logic resume_k;
  logic legacy_mode;
  logic usb_mode;
  logic legacy_data_in;
  logic legacy_clock_in;
  logic [7:0] line_rd;
  logic [7:0] epms_rd;
  logic [7:0] clk_rd;

  // ----------------------------------------------------------------
  // line conditions and timers
  // ----------------------------------------------------------------
  // low-speed idle is J (D- high); K is D+ high, D- low; SE0 both low
  assign se0 = !line_in.dp && !line_in.dm;
  assign resume_k = line_in.dp && !line_in.dm;
  assign legacy_mode = s_q.keyboard_port_select && !s_q.serial_bus_select;
  assign usb_mode = !s_q.keyboard_port_select && s_q.serial_bus_select;

  // idle timer restarts on any activity; only counts while not suspended
  uspm_count #(.LIMIT(SUSPEND_CYC)) u_idle (
    .clk(clk),
    .reset(reset),
    .run(!bus_activity && s_q.bus == USPM_ACTIVE && !legacy_mode),
    .done(idle_done)
  );

  // wake pulse length, reusing one counter for the remote wake drive
  uspm_count #(.LIMIT(WAKE_CYC)) u_wake (
    .clk(clk),
    .reset(reset),
    .run(s_q.wake),
    .done(wake_done)
  );

  // bus reset needs a sustained single-ended zero, not a short eop
  uspm_count #(.LIMIT(RESET_CYC)) u_se0 (
    .clk(clk),
    .reset(reset),
    .run(se0 && !legacy_mode),
    .done(se0_done)
  );

  // ----------------------------------------------------------------
  // ps2 line view
  // ----------------------------------------------------------------
  // an output bit at 0 pulls the line low, so the input reads 0 too
  assign legacy_data_in = line_in.dm && s_q.legacy_data_out;
  assign legacy_clock_in = line_in.dp && s_q.legacy_clock_out;

  assign line_rd = {s_q.legacy_clock_out, s_q.legacy_data_out, legacy_clock_in,
                    legacy_data_in, s_q.resume, s_q.bus_reset_event, 1'b0,
                    s_q.suspend};
  assign epms_rd = {s_q.usb_mode_indicator, 1'b0, s_q.serial_bus_select,
                    s_q.keyboard_port_select, 2'b00, s_q.endpoint_one_request,
                    s_q.endpoint_zero_request};
  assign clk_rd = {s_q.legacy_mode_indicator, s_q.rate_sel, 1'b0, s_q.resistor,
                   s_q.clk_en, 3'b000};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.irq = 1'b0;
    // read data valid only in the cycle after the strobe
    s_d.rdata = 8'h00;
    if (req.rd) begin
      if (req.addr == `USPM_OFS_LINE) begin
        s_d.rdata = line_rd;
      end else if (req.addr == `USPM_OFS_EPMS) begin
        s_d.rdata = epms_rd;
      end else if (req.addr == `USPM_OFS_CLK) begin
        s_d.rdata = clk_rd;
      end
    end
    // register writes first so that bus reset and wake end below win over writes; an endpoint access is tested against the old flag
    if (req.wr) begin
      if (req.addr == `USPM_OFS_LINE) begin
        s_d.bus_reset_event = req.wdata[2];
        s_d.legacy_data_out = req.wdata[6];
        s_d.legacy_clock_out = req.wdata[7];
        if (req.wdata[1] && s_q.bus == USPM_SUSP) begin
          s_d.wake = 1'b1;
        end
      end else if (req.addr == `USPM_OFS_EPMS) begin
        s_d.endpoint_zero_request = req.wdata[0] && s_q.endpoint_zero_request;
        s_d.endpoint_one_request = req.wdata[1] && s_q.endpoint_one_request;
        s_d.keyboard_port_select = req.wdata[4];
        s_d.serial_bus_select = req.wdata[5];
        s_d.usb_mode_indicator = req.wdata[7];
      end else if (req.addr == `USPM_OFS_CLK) begin
        s_d.clk_en = req.wdata[3];
        s_d.resistor = req.wdata[4];
        s_d.rate_sel = req.wdata[6];
        s_d.legacy_mode_indicator = req.wdata[7];
      end
    end
    if (wake_done) begin
      s_d.wake = 1'b0;
    end
    // suspend / resume sequence
    case (s_q.bus)
      USPM_ACTIVE: begin
        if (idle_done) begin
          s_d.bus = USPM_SUSP;
          s_d.suspend = 1'b1;
          s_d.irq = 1'b1;
        end
      end
      USPM_SUSP: begin
        if (resume_k && !s_q.wake) begin
          s_d.bus = USPM_RESUMING;
          s_d.resume = 1'b1;
          s_d.irq = 1'b1;
        end
      end
      USPM_RESUMING: begin
        // resume flag drops when K ends, before idle comes back
        if (!resume_k) begin
          s_d.resume = 1'b0;
        end
        if (se0 || (!resume_k && line_in.dm)) begin
          s_d.bus = USPM_ACTIVE;
          s_d.suspend = 1'b0;
          s_d.irq = 1'b1;
        end
      end
      default: begin
        s_d.bus = USPM_ACTIVE;
      end
    endcase
    if (se0_done) begin
      s_d.bus_reset_event = 1'b1;
    end
    // a pending flag blocks the next event for that endpoint
    if (ep0_access && !s_q.endpoint_zero_request) begin
      s_d.endpoint_zero_request = 1'b1;
      s_d.irq = s_d.irq || int_allowed;
    end
    if (ep1_access && !s_q.endpoint_one_request) begin
      s_d.endpoint_one_request = 1'b1;
      s_d.irq = s_d.irq || int_allowed;
    end
    if (s_d.irq && !(idle_done || s_q.bus != s_d.bus)) begin
      s_d.irq = int_allowed;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
      s_q.legacy_data_out <= 1'b1;
      s_q.legacy_clock_out <= 1'b1;
      s_q.keyboard_port_select <= 1'b0;
      s_q.serial_bus_select <= 1'b0;
      s_q.clk_en <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // pins and outputs
  // ----------------------------------------------------------------
  // ps2 is open drain: drive low only for a 0 output bit
  always_comb begin
    line_out = '0;
    line_oe_n = 2'b11;
    if (legacy_mode) begin
      line_out = '0;
      line_oe_n.dm = s_q.legacy_data_out;
      line_oe_n.dp = s_q.legacy_clock_out;
    end else if (usb_mode) begin
      if (s_q.wake) begin
        line_out.dp = 1'b1;
        line_out.dm = 1'b0;
        line_oe_n = 2'b00;
      end else begin
        line_out = sie_out;
        line_oe_n = sie_oe_n;
      end
    end
  end

  assign rdata = s_q.rdata;
  assign usb_irq = s_q.irq;
  assign bus_clock_enable = s_q.clk_en;
  assign second_suspend_resistor = s_q.resistor;
  assign oscillator_rate_select = s_q.rate_sel;
  assign remote_wake_pulse = s_q.wake;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // suspend, resume and bus reset sequence
  AST_SUSP_SET: assert property (@(posedge clk) disable iff (reset)
    idle_done |=> s_q.suspend && usb_irq) else $error("suspend not entered");
  AST_RESUME: assert property (@(posedge clk) disable iff (reset)
    s_q.bus == USPM_SUSP && resume_k && !s_q.wake |=> s_q.resume && usb_irq)
    else $error("resume not flagged");
  AST_RESUME_CLR: assert property (@(posedge clk) disable iff (reset)
    s_q.bus == USPM_RESUMING && !resume_k |=> !s_q.resume)
    else $error("resume flag not cleared");
  AST_EXIT: assert property (@(posedge clk) disable iff (reset)
    s_q.bus == USPM_RESUMING && se0 |=> !s_q.suspend && usb_irq)
    else $error("suspend not left");
  AST_BUS_RST: assert property (@(posedge clk) disable iff (reset)
    se0_done |=> s_q.bus_reset_event) else $error("bus reset missed");
  // remote wake: a write while suspended starts the drive, which forces k on the pins in usb mode
  AST_WAKE_GO: assert property (@(posedge clk) disable iff (reset)
    req.wr && req.addr == `USPM_OFS_LINE && req.wdata[1] && s_q.bus == USPM_SUSP
    && !s_q.wake |=> remote_wake_pulse)
    else $error("remote wake write ignored");
  AST_WAKE_PIN: assert property (@(posedge clk) disable iff (reset)
    usb_mode && s_q.wake |-> !line_oe_n.dp && !line_oe_n.dm && line_out.dp && !line_out.dm)
    else $error("wake pulse not on pins");
  // register fields follow the last write and read back
  AST_CLK_GATE: assert property (@(posedge clk) disable iff (reset)
    req.wr && req.addr == `USPM_OFS_CLK |=> bus_clock_enable == $past(req.wdata[3]))
    else $error("clock enable not written");
  AST_RES_BIT: assert property (@(posedge clk) disable iff (reset)
    req.wr && req.addr == `USPM_OFS_CLK |=> second_suspend_resistor == $past(req.wdata[4]))
    else $error("resistor bit not written");
  AST_USB_IND: assert property (@(posedge clk) disable iff (reset)
    req.wr && req.addr == `USPM_OFS_EPMS |=> s_q.usb_mode_indicator == $past(req.wdata[7]))
    else $error("usb mode indicator not written");
  AST_READ: assert property (@(posedge clk) disable iff (reset)
    req.rd && req.addr == `USPM_OFS_CLK |=> rdata[6] == $past(s_q.rate_sel))
    else $error("rate select readback wrong");
  // reset leaves neither mode selected and both ps2 outputs released
  AST_RST_VAL: assert property (@(posedge clk)
    $past(reset) |-> s_q.legacy_data_out && s_q.legacy_clock_out && !s_q.clk_en
    && !s_q.keyboard_port_select && !s_q.serial_bus_select)
    else $error("reset values wrong");
  // pin ownership in each line mode
  AST_PS2_IN: assert property (@(posedge clk) disable iff (reset)
    !s_q.legacy_data_out |-> !legacy_data_in) else $error("ps2 input not masked");
  AST_PS2_PIN: assert property (@(posedge clk) disable iff (reset)
    legacy_mode && !s_q.legacy_clock_out |-> !line_oe_n.dp && !line_out.dp)
    else $error("ps2 clock not driven");
  AST_PS2_DATA: assert property (@(posedge clk) disable iff (reset)
    legacy_mode && !s_q.legacy_data_out |-> !line_oe_n.dm && !line_out.dm)
    else $error("ps2 data not driven");
  AST_SIE_PASS: assert property (@(posedge clk) disable iff (reset)
    usb_mode && !s_q.wake |-> line_out == sie_out && line_oe_n == sie_oe_n)
    else $error("engine drive not passed to pins");
  // endpoint flags: set on access, held until firmware writes a 0
  AST_EP0: assert property (@(posedge clk) disable iff (reset)
    ep0_access && !s_q.endpoint_zero_request |=> s_q.endpoint_zero_request)
    else $error("endpoint 0 flag missed");
  AST_EP1: assert property (@(posedge clk) disable iff (reset)
    ep1_access && !s_q.endpoint_one_request |=> s_q.endpoint_one_request)
    else $error("endpoint 1 flag missed");
  AST_EP0_IRQ: assert property (@(posedge clk) disable iff (reset)
    ep0_access && !s_q.endpoint_zero_request && int_allowed |=> usb_irq)
    else $error("endpoint 0 interrupt missed");
  AST_EP0_HOLD: assert property (@(posedge clk) disable iff (reset)
    s_q.endpoint_zero_request && !(req.wr && req.addr == `USPM_OFS_EPMS)
    |=> s_q.endpoint_zero_request)
    else $error("endpoint 0 flag lost");
endmodule // uspm_top

// ===== verification/uspm_host_model.sv
// far-end host model: resolves the shared pins from both drivers
`timescale 1ns/100ps
module uspm_host_model (
  input wire logic host_en,
  input wire uspm_pkg::uspm_lines_t host_drive,
  input wire uspm_pkg::uspm_lines_t pull,
  input wire uspm_pkg::uspm_lines_t dev_out,
  input wire uspm_pkg::uspm_lines_t dev_oe_n,
  output uspm_pkg::uspm_lines_t wire_lvl
);
  import uspm_pkg::*;
  // --------------------------------------------------------------
  // wire resolution
  // --------------------------------------------------------------
  logic [1:0] idle;
  // an undriven pin floats to its pull; a low from either side wins
  assign idle = {2{~host_en}} & dev_oe_n;
  assign wire_lvl = (idle & pull) | (~idle & (dev_oe_n | dev_out) & ({2{~host_en}} | host_drive));
endmodule // uspm_host_model

// ===== verification/uspm_top_test.sv
// self-checking bench of the suspend, wake-up and line mode block
`timescale 1ns/100ps
module uspm_top_test;
  import uspm_pkg::*;
  // --------------------------------------------------------------
  // signals and helpers
  // --------------------------------------------------------------
  localparam int SUSP = 50;
  localparam int WAKE = 20;
  localparam int RST = 10;
  localparam logic [1:0] K = 2'b10;
  localparam logic [1:0] J = 2'b01;
  logic clk, reset, usb_irq, bce, ssr, ors, rwp, host_en;
  logic bus_activity, ep0_access, ep1_access, int_allowed;
  logic [7:0] rdata;
  uspm_req_t req;
  uspm_lines_t line_in, line_out, line_oe_n, sie_out, sie_oe_n, host_drive, pull;
  int n_fail, cmp_count, irq_n, n, base;
  logic [7:0] cv [3] = '{8'h88, 8'h50, 8'h00};
  uspm_top #(.SUSPEND_CYC(SUSP), .WAKE_CYC(WAKE), .RESET_CYC(RST)) uspm_top_i (
    .clk(clk), .reset(reset), .req(req), .rdata(rdata), .line_in(line_in),
    .line_out(line_out), .line_oe_n(line_oe_n), .sie_out(sie_out), .sie_oe_n(sie_oe_n),
    .bus_activity(bus_activity), .ep0_access(ep0_access), .ep1_access(ep1_access),
    .int_allowed(int_allowed), .usb_irq(usb_irq), .bus_clock_enable(bce),
    .second_suspend_resistor(ssr), .oscillator_rate_select(ors), .remote_wake_pulse(rwp));
  uspm_host_model uspm_host_model_i (.host_en(host_en), .host_drive(host_drive),
    .pull(pull), .dev_out(line_out), .dev_oe_n(line_oe_n), .wire_lvl(line_in));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // every pulse is counted, so unwanted ones show as well
  always @(posedge clk) if (usb_irq === 1'b1) irq_n <= irq_n + 1;
  task automatic wrap_up();
    if (n_fail == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 chk(rdata & m, e);
  endtask
  task automatic ep(input int k);
    @(posedge clk);
    if (k == 0) ep0_access <= 1'b1;
    else ep1_access <= 1'b1;
    @(posedge clk);
    ep0_access <= 1'b0;
    ep1_access <= 1'b0;
  endtask
  // the pulse lasts one cycle, so each cycle is looked at
  task automatic wait_irq(input int lim);
    n = 0;
    #1;
    while (usb_irq !== 1'b1) begin
      @(posedge clk) #1;
      n++;
      if (n > lim) begin
        n_fail++;
        wrap_up();
      end
    end
  endtask
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    reset = 1'b1;
    req = '0;
    sie_out = J;
    sie_oe_n = 2'b11;
    bus_activity = 1'b1;
    ep0_access = 1'b0;
    ep1_access = 1'b0;
    int_allowed = 1'b1;
    host_en = 1'b0;
    host_drive = J;
    pull = 2'b11;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rd(8'h1a, 8'hcf, 8'hc0);
    rd(8'h1b, 8'hff, 8'h00);
    rd(8'h1c, 8'hff, 8'h00);
    rd(8'h1d, 8'hff, 8'h00);
    chk(line_oe_n, 8'h03);
    foreach (cv[i]) begin
      wr(8'h1c, cv[i]);
      rd(8'h1c, 8'hff, cv[i]);
      chk({bce, ssr, ors}, {cv[i][3], cv[i][4], cv[i][6]});
    end
    // keyboard port mode: D- is data, D+ is clock, both open drain
    wr(8'h1b, 8'h10);
    host_en <= 1'b1;
    host_drive <= 2'b10;
    rd(8'h1a, 8'h30, 8'h20);
    host_drive <= 2'b01;
    rd(8'h1a, 8'h30, 8'h10);
    host_en <= 1'b0;
    wr(8'h1a, 8'h40);
    rd(8'h1a, 8'h30, 8'h10);
    chk(line_in, J);
    wr(8'h1a, 8'h80);
    rd(8'h1a, 8'h30, 8'h20);
    wr(8'h1a, 8'hc0);
    // usb mode: the engine owns both pins
    pull <= J;
    wr(8'h1b, 8'h20);
    sie_oe_n <= 2'b00;
    sie_out <= K;
    @(posedge clk) #1 chk({line_oe_n, line_out}, {2'b00, K});
    sie_oe_n <= 2'b11;
    @(posedge clk) #1 chk(line_oe_n, 2'b11);
    // endpoint flags: a set flag blocks the next event
    ep(0);
    wait_irq(5);
    // the pulse is tallied at the next edge, so take the base after it
    @(posedge clk) #1 base = irq_n;
    ep(0);
    repeat (5) @(posedge clk);
    chk(8'(irq_n - base), 8'h00);
    int_allowed <= 1'b0;
    ep(1);
    repeat (5) @(posedge clk);
    chk(8'(irq_n - base), 8'h00);
    int_allowed <= 1'b1;
    wr(8'h1b, 8'h23);
    rd(8'h1b, 8'hff, 8'h23);
    wr(8'h1b, 8'h20);
    rd(8'h1b, 8'hff, 8'h20);
    ep(0);
    wait_irq(5);
    wr(8'h1b, 8'h20);
    // long single-ended zero is a bus reset
    host_en <= 1'b1;
    host_drive <= 2'b00;
    repeat (RST + 5) @(posedge clk);
    host_en <= 1'b0;
    rd(8'h1a, 8'h04, 8'h04);
    wr(8'h1a, 8'hc0);
    rd(8'h1a, 8'h04, 8'h00);
    // quiet bus leads to suspend after the idle time
    @(posedge clk);
    bus_activity <= 1'b0;
    wait_irq(SUSP + 10);
    chk(8'(n >= SUSP - 1 && n <= SUSP + 3), 8'h01);
    rd(8'h1a, 8'h0b, 8'h01);
    // resistor on with clock off; rate select and indicator bits stay 0
    wr(8'h1c, 8'h10);
    // remote wake: K on the pins for the wake time
    wr(8'h1a, 8'hc2);
    #1 chk({line_oe_n, line_out}, {2'b00, K});
    for (n = 0; rwp === 1'b1 && n < WAKE + 5; n++) @(posedge clk) #1;
    chk(8'(n >= WAKE - 1 && n <= WAKE + 1), 8'h01);
    // host answers with resume K, then ends it
    host_en <= 1'b1;
    host_drive <= K;
    wait_irq(10);
    rd(8'h1a, 8'h09, 8'h09);
    wr(8'h1c, 8'h08);
    host_drive <= 2'b00;
    wait_irq(10);
    host_en <= 1'b0;
    bus_activity <= 1'b1;
    rd(8'h1a, 8'h09, 8'h00);
    rd(8'h1c, 8'hff, 8'h08);
    wrap_up();
  end
endmodule // uspm_top_test
